//--- verilog/bmsp_pkg.sv
// Shared constants and state encoding for the biphase-mark serial port block
package bmsp_pkg;

   // ----------------------------------------------------------------
   // Line timing, in link clock cycles and half-bit periods
   // ----------------------------------------------------------------
   localparam int BMSP_HALF_CYC = 4;
   localparam int BMSP_IDLE_HALVES = 6;
   localparam int BMSP_SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // Reset values of the pins and status, and the level driven on open-drain pins
   // ----------------------------------------------------------------
   localparam logic BMSP_RST_RELEASED = 1'b1;
   localparam logic BMSP_RST_LEVEL = 1'b0;
   localparam logic BMSP_OD_LOW = 1'b0;

   // ----------------------------------------------------------------
   // Link side states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      BMSP_ST_IDLE = 4'b0001,
      BMSP_ST_RX = 4'b0010,
      BMSP_ST_TX = 4'b0100,
      BMSP_ST_TAIL = 4'b1000
   } bmsp_state_e;

endpackage

//--- verilog/bmsp_sync.sv
// Two flip-flop level synchroniser, a bus of independent bits
`timescale 1ns/1ps
module bmsp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,               // Destination clock
   input wire logic rst_n,             // Destination reset, active low
   input wire logic [WIDTH-1:0] d,     // Asynchronous levels
   output logic [WIDTH-1:0] q          // Synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   if (WIDTH < 1) begin : g_bad_width
      $error("bmsp_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule

//--- verilog/bmsp_port.sv
// Biphase-mark serial port to the microcontroller, orientation and power path pins
`timescale 1ns/1ps
// Contract
// - Receive: decoded line data on mosi, valid at serial clock falling edge.
// - Transmit: miso sampled at serial clock rising edge; sender holds it stable.
// - Frame select is active-low open drain, low while a transfer runs.
// - With tx_en high, serial data is biphase-mark encoded onto the line.
// - With tx_en low, line activity is detected, decoded and sent out.
// - Transmit wins: tx_en abandons any receive in progress.
// - Serial clock is open drain and times both data directions.
// - Orientation pin released for first line, driven low for second.
// - Detected orientation is also given as a status bit.
// - Sink enable only when attached to a source with bus in range.
// - Source enable only when attached to a sink with bus in range.
// - Source enable also needs enabled supply under/overvoltage checks passed.
// - Plug power goes on the line not carrying the connection.
// - The connected line reaches the coder only while attached.
// - tx_en low ends transmit with trailing edge, then line is released.
// - Receive pulls frame select low; releases it when activity stops.
module bmsp_port
   import bmsp_pkg::*;
#(
   parameter int HALF_CYC = BMSP_HALF_CYC,
   parameter int IDLE_HALVES = BMSP_IDLE_HALVES
) (
   input wire logic sys_clk,               // Control clock, 250 MHz
   input wire logic resetn,                // Asynchronous reset, active low
   input wire logic bit_clk,               // Link clock for line and serial port
   input wire logic attached,              // Connection established
   input wire logic cc2_active,            // Second line carries the connection
   input wire logic role_source,           // 1 source role, 0 sink role
   input wire logic vbus_in_range,         // Bus voltage in valid range
   input wire logic uvlo_chk_en,           // Supply undervoltage check enabled
   input wire logic ovlo_chk_en,           // Supply overvoltage check enabled
   input wire logic uvlo_ok,               // Supply above undervoltage limit
   input wire logic ovlo_ok,               // Supply below overvoltage limit
   input wire logic vconn_sw_en,           // Plug power switches enabled
   input wire logic tx_en,                 // Transmit enable pin
   input wire logic miso,                  // Transmit data pin
   output logic mosi,                      // Receive data pin
   output logic sclk_o,                    // Serial clock level when driven
   output logic sclk_oe_n,                 // Serial clock drive, low drives
   output logic frame_select_n_o,          // Frame select level when driven
   output logic frame_select_n_oe_n,       // Frame select drive, low drives
   input wire logic cc1_i,                 // First line level
   output logic cc1_o,                     // First line drive level
   output logic cc1_oe_n,                  // First line drive, low drives
   input wire logic cc2_i,                 // Second line level
   output logic cc2_o,                     // Second line drive level
   output logic cc2_oe_n,                  // Second line drive, low drives
   output logic orient_o,                  // Orientation level when driven
   output logic orient_oe_n,               // Orientation drive, low drives
   output logic orient_status,             // Orientation status bit
   output logic sink_path_enable_n_o,      // Sink enable level when driven
   output logic sink_path_enable_n_oe_n,   // Sink enable drive, low drives
   output logic sink_path_status,          // Sink enable pin level
   output logic source_path_enable_n_o,    // Source enable level when driven
   output logic source_path_enable_n_oe_n, // Source enable drive, low drives
   output logic source_path_status,        // Source enable pin level
   output logic vconn_cc1_en,              // Plug power onto first line
   output logic vconn_cc2_en,              // Plug power onto second line
   output logic bmc_tx_busy                // Transmit in progress, control clock
);
   localparam int IDLE_CYC = HALF_CYC * IDLE_HALVES;
   localparam int CW = $clog2(IDLE_CYC + 1);
   localparam logic [CW-1:0] HALF_M1 = CW'(HALF_CYC - 1);
   localparam logic [CW-1:0] FALL_AT = CW'(HALF_CYC / 2 - 1);
   localparam logic [CW-1:0] SHORT_MAX = CW'(HALF_CYC + HALF_CYC / 2);
   localparam logic [CW-1:0] IDLE_M1 = CW'(IDLE_CYC - 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(IDLE_CYC);
   localparam int TAIL_BOUND = HALF_CYC;

   if (HALF_CYC < 4 || IDLE_HALVES < 3) begin : g_bad_param
      $error("bmsp_port: HALF_CYC must be >= 4 and IDLE_HALVES >= 3");
   end

   // ----------------------------------------------------------------
   // Control clock side: orientation and power path
   // ----------------------------------------------------------------
   logic orient_oe_n_q, orient_oe_n_d;
   logic orient_st_q, orient_st_d;
   logic sink_n_q, sink_n_d;
   logic src_n_q, src_n_d;
   logic vc1_q, vc1_d;
   logic vc2_q, vc2_d;
   logic busy_s;

   always_comb begin
      orient_oe_n_d = !(attached && cc2_active);
      orient_st_d = attached && cc2_active;
      sink_n_d = !(attached && !role_source && vbus_in_range);
      src_n_d = !(attached && role_source && vbus_in_range
                  && (!uvlo_chk_en || uvlo_ok)
                  && (!ovlo_chk_en || ovlo_ok));
      vc1_d = attached && role_source && vconn_sw_en && cc2_active;
      vc2_d = attached && role_source && vconn_sw_en && !cc2_active;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         orient_oe_n_q <= BMSP_RST_RELEASED;
         orient_st_q <= BMSP_RST_LEVEL;
         sink_n_q <= BMSP_RST_RELEASED;
         src_n_q <= BMSP_RST_RELEASED;
         vc1_q <= BMSP_RST_LEVEL;
         vc2_q <= BMSP_RST_LEVEL;
      end else begin
         orient_oe_n_q <= orient_oe_n_d;
         orient_st_q <= orient_st_d;
         sink_n_q <= sink_n_d;
         src_n_q <= src_n_d;
         vc1_q <= vc1_d;
         vc2_q <= vc2_d;
      end
   end

   assign orient_o = BMSP_OD_LOW;
   assign orient_oe_n = orient_oe_n_q;
   assign orient_status = orient_st_q;
   assign sink_path_enable_n_o = BMSP_OD_LOW;
   assign sink_path_enable_n_oe_n = sink_n_q;
   // Status mirrors the pin's logic value, so it reads 0 while enabled
   assign sink_path_status = sink_n_q;
   assign source_path_enable_n_o = BMSP_OD_LOW;
   assign source_path_enable_n_oe_n = src_n_q;
   assign source_path_status = src_n_q;
   assign vconn_cc1_en = vc1_q;
   assign vconn_cc2_en = vc2_q;

   // ----------------------------------------------------------------
   // Crossings and link reset
   // ----------------------------------------------------------------
   logic [1:0] rst_bit_q;
   logic rst_bit_n;
   logic att_s, sel_s, tx_en_s, miso_s, cc1_s, cc2_s;
   bmsp_state_e state_q, state_d;
   logic busy_lnk_q, busy_lnk_d;

   // Asserts with resetn, releases on the link clock
   always_ff @(posedge bit_clk or negedge resetn) begin
      if (!resetn) begin
         rst_bit_q <= 2'h0;
      end else begin
         rst_bit_q <= {rst_bit_q[0], 1'b1};
      end
   end
   assign rst_bit_n = rst_bit_q[1];

   bmsp_sync #(.WIDTH(6)) u_sync_link (
      .clk(bit_clk),
      .rst_n(rst_bit_n),
      .d({attached, cc2_active, tx_en, miso, cc1_i, cc2_i}),
      .q({att_s, sel_s, tx_en_s, miso_s, cc1_s, cc2_s})
   );

   // Busy leaves the link side from a flop, so no state decode glitch crosses
   bmsp_sync #(.WIDTH(1)) u_sync_busy (
      .clk(sys_clk),
      .rst_n(resetn),
      .d(busy_lnk_q),
      .q(busy_s)
   );
   assign bmc_tx_busy = busy_s;

   // ----------------------------------------------------------------
   // Link side: coder, decoder and serial port
   // ----------------------------------------------------------------
   logic [CW-1:0] cnt_q, cnt_d;
   logic phase_q, phase_d;
   logic lvl_q, lvl_d;
   logic bit_q, bit_d;
   logic enc_q, enc_d;
   logic last_q, last_d;
   logic half_q, half_d;
   logic pulse_q, pulse_d;
   logic sclk_q, sclk_d;
   logic fsel_q, fsel_d;
   logic mosi_q, mosi_d;
   logic prev_q;
   logic rx_line, rx_edge, drive;

   // Only the connected line is looked at, and only while attached
   assign rx_line = sel_s ? cc2_s : cc1_s;
   assign rx_edge = att_s && (rx_line != prev_q);

   always_comb begin
      state_d = state_q;
      cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1;
      phase_d = phase_q;
      lvl_d = lvl_q;
      bit_d = bit_q;
      enc_d = enc_q;
      last_d = last_q;
      half_d = half_q;
      pulse_d = pulse_q;
      sclk_d = sclk_q;
      fsel_d = fsel_q;
      mosi_d = mosi_q;
      case (state_q)
         BMSP_ST_IDLE: begin
            fsel_d = 1'b1;
            sclk_d = 1'b1;
            lvl_d = 1'b0;
            if (tx_en_s && att_s) begin
               state_d = BMSP_ST_TX;
               cnt_d = '0;
               phase_d = 1'b0;
               enc_d = 1'b0;
               last_d = 1'b0;
               fsel_d = 1'b0;
               sclk_d = 1'b0;
            end else if (rx_edge) begin
               state_d = BMSP_ST_RX;
               cnt_d = '0;
               half_d = 1'b0;
               pulse_d = 1'b0;
               fsel_d = 1'b0;
            end
         end
         BMSP_ST_RX: begin
            if (tx_en_s && att_s) begin
               state_d = BMSP_ST_TX;
               cnt_d = '0;
               phase_d = 1'b0;
               enc_d = 1'b0;
               last_d = 1'b0;
               sclk_d = 1'b0;
            end else if (!att_s) begin
               state_d = BMSP_ST_IDLE;
               fsel_d = 1'b1;
               sclk_d = 1'b1;
            end else if (rx_edge) begin
               cnt_d = '0;
               sclk_d = 1'b1;
               pulse_d = 1'b0;
               // Short gaps pair into a one, a long gap is a zero
               if (cnt_q < SHORT_MAX) begin
                  half_d = !half_q;
                  if (half_q) begin
                     mosi_d = 1'b1;
                     pulse_d = 1'b1;
                  end
               end else begin
                  half_d = 1'b0;
                  mosi_d = 1'b0;
                  pulse_d = 1'b1;
               end
            end else begin
               // Falling edge lands mid-interval, well after mosi settled
               if (pulse_q && cnt_q == FALL_AT) begin
                  sclk_d = 1'b0;
               end
               if (cnt_q == HALF_M1) begin
                  sclk_d = 1'b1;
                  pulse_d = 1'b0;
               end
               if (cnt_q == IDLE_M1) begin
                  state_d = BMSP_ST_IDLE;
                  fsel_d = 1'b1;
                  sclk_d = 1'b1;
               end
            end
         end
         BMSP_ST_TX: begin
            if (!att_s) begin
               state_d = BMSP_ST_IDLE;
               fsel_d = 1'b1;
               sclk_d = 1'b1;
               lvl_d = 1'b0;
            end else if (cnt_q == HALF_M1) begin
               cnt_d = '0;
               if (!phase_q) begin
                  phase_d = 1'b1;
                  sclk_d = 1'b1;
                  if (!last_q) begin
                     bit_d = miso_s;
                  end
                  if (enc_q) begin
                     lvl_d = !lvl_q;
                  end
               end else begin
                  phase_d = 1'b0;
                  enc_d = bit_q;
                  lvl_d = !lvl_q;
                  if (last_q) begin
                     state_d = BMSP_ST_TAIL;
                     sclk_d = 1'b1;
                  end else if (!tx_en_s) begin
                     // One more bit carries the last sampled data, clock held
                     last_d = 1'b1;
                     sclk_d = 1'b1;
                  end else begin
                     sclk_d = 1'b0;
                  end
               end
            end
         end
         BMSP_ST_TAIL: begin
            if (cnt_q == HALF_M1 || !att_s) begin
               state_d = BMSP_ST_IDLE;
               fsel_d = 1'b1;
               sclk_d = 1'b1;
               lvl_d = 1'b0;
            end
         end
         default: begin
            state_d = BMSP_ST_IDLE;
            fsel_d = 1'b1;
            sclk_d = 1'b1;
         end
      endcase
      busy_lnk_d = (state_d == BMSP_ST_TX) || (state_d == BMSP_ST_TAIL);
   end

   always_ff @(posedge bit_clk or negedge rst_bit_n) begin
      if (!rst_bit_n) begin
         state_q <= BMSP_ST_IDLE;
         cnt_q <= '0;
         phase_q <= 1'b0;
         lvl_q <= BMSP_RST_LEVEL;
         bit_q <= 1'b0;
         enc_q <= 1'b0;
         last_q <= 1'b0;
         half_q <= 1'b0;
         pulse_q <= 1'b0;
         sclk_q <= BMSP_RST_RELEASED;
         fsel_q <= BMSP_RST_RELEASED;
         mosi_q <= BMSP_RST_LEVEL;
         prev_q <= BMSP_RST_LEVEL;
         busy_lnk_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         phase_q <= phase_d;
         lvl_q <= lvl_d;
         bit_q <= bit_d;
         enc_q <= enc_d;
         last_q <= last_d;
         half_q <= half_d;
         pulse_q <= pulse_d;
         sclk_q <= sclk_d;
         fsel_q <= fsel_d;
         mosi_q <= mosi_d;
         prev_q <= rx_line;
         busy_lnk_q <= busy_lnk_d;
      end
   end

   assign drive = (state_q == BMSP_ST_TX) || (state_q == BMSP_ST_TAIL);
   assign cc1_o = lvl_q;
   assign cc2_o = lvl_q;
   assign cc1_oe_n = !(drive && !sel_s);
   assign cc2_oe_n = !(drive && sel_s);
   assign mosi = mosi_q;
   assign sclk_o = BMSP_OD_LOW;
   assign sclk_oe_n = sclk_q;
   assign frame_select_n_o = BMSP_OD_LOW;
   assign frame_select_n_oe_n = fsel_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_orient_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
      (attached && cc2_active) |=> (!orient_oe_n && orient_status))
      else $error("orientation pin not driven low for second line");

   chk_sink_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      !sink_path_enable_n_oe_n |-> $past(attached && !role_source && vbus_in_range))
      else $error("sink enable asserted without its conditions");

   chk_source_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      !source_path_enable_n_oe_n |->
         $past(vbus_in_range && role_source && (!uvlo_chk_en || uvlo_ok) && (!ovlo_chk_en || ovlo_ok)))
      else $error("source enable asserted while a check fails");

   chk_vconn_side: assert property (@(posedge sys_clk) disable iff (!resetn)
      vconn_cc1_en |-> (!vconn_cc2_en && $past(cc2_active)))
      else $error("plug power placed on the connected line");

   chk_sclk_idle: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      fsel_q |-> sclk_q)
      else $error("serial clock low while frame select released");

   chk_tx_priority: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      (state_q == BMSP_ST_RX && tx_en_s && att_s) |=> (state_q == BMSP_ST_TX && !fsel_q))
      else $error("receive not abandoned for transmit");

   chk_tx_sample: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      (state_q == BMSP_ST_TX && att_s && !phase_q && !last_q && cnt_q == HALF_M1)
         |=> (sclk_q && bit_q == $past(miso_s)))
      else $error("transmit data not taken at serial clock rise");

   chk_tail_end: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      $rose(state_q == BMSP_ST_TAIL) |-> ##[1:TAIL_BOUND] (state_q == BMSP_ST_IDLE && cc1_oe_n && cc2_oe_n))
      else $error("line not released after trailing edge");

   chk_rx_end: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      (state_q == BMSP_ST_RX && att_s && !tx_en_s && !rx_edge && cnt_q == IDLE_M1)
         |=> (fsel_q && state_q == BMSP_ST_IDLE))
      else $error("frame select held after line went quiet");

   chk_line_route: assert property (@(posedge bit_clk) disable iff (!rst_bit_n)
      (!cc1_oe_n || !cc2_oe_n) |-> $past(att_s))
      else $error("line driven while not attached");
endmodule

//--- verification/bmsp_mcu_model.sv
// Microcontroller serial slave model facing the biphase-mark serial port
`timescale 1ns/1ps
module bmsp_mcu_model (
   input wire logic sclk,          // Serial clock as seen on the wire
   input wire logic fsel_n,        // Frame select as seen on the wire
   input wire logic mosi,          // Receive data from the port
   input wire logic tx_req,        // Bench asks for a transmission
   input wire logic [7:0] tx_byte, // Byte sent over and over, LSB first
   output logic tx_en,             // Transmit enable pin
   output logic miso,              // Transmit data pin
   output logic [7:0] rx_byte,     // Last eight bits received, LSB first
   output logic [7:0] rx_cnt       // Bits received so far
);
   logic [2:0] idx_q;
   // Held low whenever no transmission is wanted
   assign tx_en = tx_req;
   // Bit changes just after a falling edge, so it stands across the rising sample
   assign miso = tx_byte[idx_q - 3'h1];
   initial begin
      idx_q = 3'h0;
      rx_byte = 8'h00;
      rx_cnt = 8'h00;
   end
   always @(negedge sclk or negedge tx_en) begin
      if (!tx_en) begin
         idx_q <= 3'h0;
      end else begin
         idx_q <= idx_q + 3'h1;
      end
   end
   always @(negedge sclk) begin
      if (!fsel_n && !tx_en) begin
         rx_byte <= {mosi, rx_byte[7:1]};
         rx_cnt <= rx_cnt + 8'h01;
      end
   end
endmodule

//--- verification/bmsp_port_bench.sv
// Self-checking bench for the biphase-mark serial port block
`timescale 1ns/1ps
module bmsp_port_bench;
   import bmsp_pkg::*;
   localparam int H = BMSP_HALF_CYC;
   logic sys_clk, bit_clk, resetn, line1, tx_req, tx_en, miso, mosi;
   logic [8:0] ctl;
   logic [7:0] tx_byte, rx_byte, rx_cnt;
   logic sclk_o, sclk_oe_n, fs_o, fs_oe_n, cc1_o, cc1_oe_n, cc2_o, cc2_oe_n;
   logic or_o, or_oe_n, or_st, sk_o, sk_oe_n, sk_st, sr_o, sr_oe_n, sr_st, vc1, vc2, busy;
   // Open-drain pins rest high through their pull-ups
   wire sclk_w = sclk_oe_n ? 1'b1 : sclk_o;
   wire fsel_w = fs_oe_n ? 1'b1 : fs_o;
   int err_total = 0, checks = 0, tog = 0, stray = 0;
   bmsp_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .bit_clk(bit_clk), .attached(ctl[8]),
      .cc2_active(ctl[7]), .role_source(ctl[6]), .vbus_in_range(ctl[5]), .uvlo_chk_en(ctl[4]),
      .ovlo_chk_en(ctl[3]), .uvlo_ok(ctl[2]), .ovlo_ok(ctl[1]), .vconn_sw_en(ctl[0]),
      .tx_en(tx_en), .miso(miso), .mosi(mosi), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
      .frame_select_n_o(fs_o), .frame_select_n_oe_n(fs_oe_n),
      .cc1_i(cc1_oe_n ? line1 : cc1_o), .cc1_o(cc1_o), .cc1_oe_n(cc1_oe_n),
      .cc2_i(cc2_oe_n ? 1'b0 : cc2_o), .cc2_o(cc2_o), .cc2_oe_n(cc2_oe_n),
      .orient_o(or_o), .orient_oe_n(or_oe_n), .orient_status(or_st),
      .sink_path_enable_n_o(sk_o), .sink_path_enable_n_oe_n(sk_oe_n),
      .sink_path_status(sk_st), .source_path_enable_n_o(sr_o),
      .source_path_enable_n_oe_n(sr_oe_n), .source_path_status(sr_st),
      .vconn_cc1_en(vc1), .vconn_cc2_en(vc2), .bmc_tx_busy(busy));
   bmsp_mcu_model mcu_u (.sclk(sclk_w), .fsel_n(fsel_w), .mosi(mosi), .tx_req(tx_req),
      .tx_byte(tx_byte), .tx_en(tx_en), .miso(miso), .rx_byte(rx_byte), .rx_cnt(rx_cnt));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      bit_clk = 1'b0;
      #37;
      forever #80 bit_clk = ~bit_clk;
   end
   always @(cc1_o) if (!cc1_oe_n) tog++;
   // Settle first: select and clock may move in one time step
   always @(negedge sclk_w) begin
      #1;
      if (fsel_w) stray++;
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic flip(input int halves);
      repeat (halves * H) @(posedge bit_clk);
      @(posedge sys_clk) line1 <= ~line1;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_power();
      logic a, e_sk, e_sr;
      for (int i = 0; i < 512; i++) begin
         @(posedge sys_clk) ctl <= i[8:0];
         @(posedge sys_clk);
         #1;
         a = ctl[8];
         e_sk = !(a && !ctl[6] && ctl[5]);
         e_sr = !(a && ctl[6] && ctl[5] && (!ctl[4] || ctl[2]) && (!ctl[3] || ctl[1]));
         cmp("orient", {6'h0, !(a && ctl[7]), a && ctl[7]}, {6'h0, or_oe_n, or_st});
         cmp("sink", {6'h0, e_sk, e_sk}, {6'h0, sk_oe_n, sk_st});
         cmp("source", {6'h0, e_sr, e_sr}, {6'h0, sr_oe_n, sr_st});
         cmp("vconn", {6'h0, a && ctl[6] && ctl[0] && ctl[7], a && ctl[6] && ctl[0] && !ctl[7]},
            {6'h0, vc1, vc2});
      end
      @(posedge sys_clk) ctl <= 9'h120;
      $display("power test done");
   endtask
   task automatic t_rx(input logic [7:0] b);
      logic [7:0] c0;
      c0 = rx_cnt;
      flip(1);
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            flip(1);
            flip(1);
         end else begin
            flip(2);
         end
      end
      repeat (2 * H) @(posedge bit_clk);
      cmp("rx_select", 8'h00, {7'h0, fsel_w});
      cmp("rx_bits", 8'h08, rx_cnt - c0);
      cmp("rx_data", b, rx_byte);
      repeat ((BMSP_IDLE_HALVES + 2) * H) @(posedge bit_clk);
      cmp("rx_release", 8'h01, {7'h0, fsel_w});
      $display("receive test done");
   endtask
   task automatic t_tx();
      int n;
      n = 0;
      tog = 0;
      @(posedge sys_clk) tx_req <= 1'b1;
      while (fsel_w !== 1'b0 && n < 40) begin
         @(posedge bit_clk);
         n++;
      end
      @(posedge bit_clk);
      cmp("tx_start", 8'h00, {6'h0, cc1_oe_n, !cc2_oe_n});
      repeat (16) @(posedge sclk_w);
      cmp("tx_busy", 8'h01, {7'h0, busy});
      @(posedge sys_clk) tx_req <= 1'b0;
      repeat (8 * H) @(posedge bit_clk);
      cmp("tx_end", 8'h07, {5'h0, sclk_w, cc1_oe_n, !busy});
      cmp("tx_toggles", 8'h01, {7'h0, tog >= 16});
      repeat (8 * H) @(posedge bit_clk);
      cmp("tx_select_off", 8'h01, {7'h0, fsel_w});
      $display("transmit test done");
   endtask
   task automatic t_prio();
      flip(1);
      flip(2);
      @(posedge sys_clk) tx_req <= 1'b1;
      repeat (8) @(posedge bit_clk);
      cmp("tx_priority", 8'h02, {6'h0, busy, cc1_oe_n});
      @(posedge sys_clk) tx_req <= 1'b0;
      repeat (16 * H) @(posedge bit_clk);
      @(posedge sys_clk) ctl <= 9'h020;
      @(posedge sys_clk) tx_req <= 1'b1;
      repeat (8 * H) @(posedge bit_clk);
      cmp("tx_refused", 8'h03, {6'h0, fsel_w, cc1_oe_n});
      @(posedge sys_clk) tx_req <= 1'b0;
      cmp("stray_clock", 8'h00, stray[7:0]);
      $display("priority test done");
   endtask
   initial begin
      resetn = 1'b0;
      line1 = 1'b0;
      tx_req = 1'b0;
      tx_byte = 8'h5a;
      ctl = 9'h000;
      repeat (3) @(posedge bit_clk);
      cmp("reset_pins", 8'hfe, {sclk_oe_n, fs_oe_n, cc1_oe_n, cc2_oe_n, or_oe_n, sk_oe_n,
         sr_oe_n, busy});
      cmp("od_levels", 8'h00, {1'h0, sclk_o, fs_o, or_o, sk_o, sr_o, cc1_o,
         cc2_o});
      @(posedge sys_clk) resetn <= 1'b1;
      repeat (6) @(posedge bit_clk);
      $display("reset test done");
      t_power();
      repeat (6) @(posedge bit_clk);
      t_rx(8'ha5);
      t_rx(8'h3c);
      t_tx();
      t_prio();
      print_verdict();
   end
   // Whole run needs just under 100 us, so twice that is ample
   initial begin
      #200us;
      err_total++;
      print_verdict();
   end
endmodule
